// ---- src/instr_decoder.sv ----
// Decode and execute core for 14-bit instruction words, with an APB slave.
// Assumes program memory answers PROG_ADDR_O within three clocks, same clock.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "decoder_cfg.svh"
module instr_decoder (
	input  wire logic        CLK_I,
	input  wire logic        RESET_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	output logic      [12:0] PROG_ADDR_O,
	input  wire logic [13:0] PROG_WORD_I,
	input  wire logic [5:0]  PIN_I,
	output logic      [5:0]  PORT_LATCH_O,
	output logic             PRESCALER_CLEAR_O,
	output logic             SLEEP_O
);
	import decoder_pkg::*;

	localparam logic [1:0]  PHASE_EXEC = 2'(`PHASE_COUNT - 1);
	localparam logic [13:0] NOP_WORD   = `NOP_WORD;

	// Decrement-skip or increment-skip word
	function automatic logic is_skip_op(input logic [13:0] w);
		is_skip_op = (w[13:12] == 2'b00) && w[11] && w[9] && w[8];
	endfunction

	logic [1:0]   phase_q, phase_d;
	logic [13:0]  instr_q, instr_d;
	logic [12:0]  pc_q, pc_d;
	logic [7:0]   w_q, w_d;
	logic [4:0]   status_q, status_d;
	logic [5:0]   port_q, port_d;
	logic         pclr_q, pclr_d;
	logic         sleep_q, sleep_d;
	logic [12:0]  stack_q [0:7];
	logic [12:0]  stack_d [0:7];
	logic [2:0]   sp_q, sp_d;
	logic [1:0]   ctl_q, ctl_d;
	logic [31:0]  prdata_q, prdata_d;
	logic [5:0]   pin_meta_q, pin_sync_q;
	logic         running, exec, wake, apb_wr, apb_rd, mapped;
	logic [7:0]   operand, ram_rdata, alu_a, alu_res;
	logic         alu_c, alu_dc, alu_z;
	alu_op_type   alu_op;
	flag_sel_type flag_sel;
	logic         res_to_file, res_to_w, branch, skip, push, pop;
	logic         go_sleep, clr_wdt, ram_we;
	logic [12:0]  target, top_addr;
	logic [6:0]   faddr;

	assign running  = ctl_q[`CTL_RUN] && !sleep_q;
	assign exec     = running && (phase_q == PHASE_EXEC);
	assign faddr    = instr_q[6:0];
	assign top_addr = stack_q[3'(sp_q - 3'h1)];

	// Operand source; a port read sees the pins, not the latch
	always_comb
	begin
		if (faddr == `ADDR_PORT)
			operand = {2'b00, pin_sync_q};
		else if (faddr == `ADDR_STATUS)
			operand = {3'b000, status_q};
		else
			operand = ram_rdata;
	end

	// Instruction decode
	always_comb
	begin
		alu_op      = ALU_PASS;
		alu_a       = operand;
		flag_sel    = UPD_NONE;
		res_to_file = 1'b0;
		res_to_w    = 1'b0;
		branch      = 1'b0;
		skip        = 1'b0;
		push        = 1'b0;
		pop         = 1'b0;
		go_sleep    = 1'b0;
		clr_wdt     = 1'b0;
		target      = top_addr;
		unique case (instr_q[13:12])
			2'b00:
			begin
				res_to_file = instr_q[7];
				res_to_w    = !instr_q[7];
				unique case (instr_q[11:8])
					4'b0000:
					begin
						res_to_w    = 1'b0;
						res_to_file = instr_q[7];
						alu_a       = w_q;
						go_sleep    = (instr_q == `SLEEP_WORD);
						clr_wdt     = (instr_q == `WDT_CLEAR_WORD);
						pop         = !instr_q[7] &&
						              (instr_q[7:1] == 7'b0000100);
						branch      = pop;
					end
					4'b0001:
					begin
						alu_op   = ALU_CLR;
						flag_sel = UPD_Z;
					end
					4'b0010:
					begin
						alu_op   = ALU_SUB;
						flag_sel = UPD_CDCZ;
					end
					4'b0011:
					begin
						alu_op   = ALU_DEC;
						flag_sel = UPD_Z;
					end
					4'b0100:
					begin
						alu_op   = ALU_OR;
						flag_sel = UPD_Z;
					end
					4'b0101:
					begin
						alu_op   = ALU_AND;
						flag_sel = UPD_Z;
					end
					4'b0110:
					begin
						alu_op   = ALU_XOR;
						flag_sel = UPD_Z;
					end
					4'b0111:
					begin
						alu_op   = ALU_ADD;
						flag_sel = UPD_CDCZ;
					end
					4'b1000: flag_sel = UPD_Z;
					4'b1001:
					begin
						alu_op   = ALU_COM;
						flag_sel = UPD_Z;
					end
					4'b1010:
					begin
						alu_op   = ALU_INC;
						flag_sel = UPD_Z;
					end
					4'b1011: alu_op = ALU_DEC;
					4'b1100:
					begin
						alu_op   = ALU_RR;
						flag_sel = UPD_C;
					end
					4'b1101:
					begin
						alu_op   = ALU_RL;
						flag_sel = UPD_C;
					end
					4'b1110: alu_op = ALU_SWAP;
					4'b1111: alu_op = ALU_INC;
				endcase
				skip = is_skip_op(instr_q) && alu_z;
			end
			2'b01:
			begin
				// Bit clear, bit set, test and skip
				unique case (instr_q[11:10])
					2'b00: alu_op = ALU_BCLR;
					2'b01: alu_op = ALU_BSET;
					2'b10: skip = !operand[instr_q[9:7]];
					2'b11: skip = operand[instr_q[9:7]];
				endcase
				res_to_file = !instr_q[11];
			end
			2'b10:
			begin
				// Jump or call within the current page
				target = {pc_q[12:11], instr_q[10:0]};
				branch = 1'b1;
				push   = !instr_q[11];
			end
			2'b11:
			begin
				alu_a    = instr_q[7:0];
				res_to_w = 1'b1;
				unique casez (instr_q[11:8])
					4'b00??: alu_op = ALU_PASS;
					4'b01??:
					begin
						pop    = 1'b1;
						branch = 1'b1;
					end
					4'b1000:
					begin
						alu_op   = ALU_OR;
						flag_sel = UPD_Z;
					end
					4'b1001:
					begin
						alu_op   = ALU_AND;
						flag_sel = UPD_Z;
					end
					4'b1010:
					begin
						alu_op   = ALU_XOR;
						flag_sel = UPD_Z;
					end
					4'b110?:
					begin
						alu_op   = ALU_SUB;
						flag_sel = UPD_CDCZ;
					end
					4'b111?:
					begin
						alu_op   = ALU_ADD;
						flag_sel = UPD_CDCZ;
					end
					default: res_to_w = 1'b0;
				endcase
			end
		endcase
	end

	alu_unit u_alu (
		.op_i  (alu_op),
		.a_i   (alu_a),
		.w_i   (w_q),
		.bit_i (instr_q[9:7]),
		.cin_i (status_q[`ST_C]),
		.res_o (alu_res),
		.c_o   (alu_c),
		.dc_o  (alu_dc),
		.z_o   (alu_z)
	);

	assign ram_we = exec && res_to_file && (faddr != `ADDR_STATUS) &&
	                (faddr != `ADDR_PORT);

	file_ram u_ram (
		.clk_i     (CLK_I),
		.reset_i   (RESET_I),
		.rd_en_i   (running && (phase_q == 2'd1)),
		.rd_addr_i (faddr),
		.wr_en_i   (ram_we),
		.wr_addr_i (faddr),
		.wr_data_i (alu_res),
		.rd_data_o (ram_rdata)
	);

	// APB decode; zero wait states, unmapped offsets answer with an error
	assign apb_wr    = PSEL_I && PENABLE_I && PWRITE_I;
	assign apb_rd    = PSEL_I && !PENABLE_I && !PWRITE_I;
	assign mapped    = (PADDR_I == `REG_CONTROL) || (PADDR_I == `REG_STATE) ||
	                   (PADDR_I == `REG_PC);
	assign wake      = apb_wr && (PADDR_I == `REG_CONTROL) &&
	                   PWDATA_I[`CTL_WAKE];
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;

	// Next state of core, stack and bus registers
	always_comb
	begin
		phase_d  = running ? 2'(phase_q + 2'd1) : phase_q;
		instr_d  = instr_q;
		pc_d     = pc_q;
		w_d      = w_q;
		status_d = status_q;
		port_d   = port_q;
		stack_d  = stack_q;
		sp_d     = sp_q;
		sleep_d  = sleep_q;
		pclr_d   = 1'b0;
		if (exec)
		begin
			// Fetched word is replaced by a no-op after a jump or skip
			instr_d = (branch || skip) ? NOP_WORD : PROG_WORD_I;
			pc_d    = branch ? target : 13'(pc_q + 13'h1);
			if (res_to_w)
				w_d = alu_res;
			if (res_to_file && (faddr == `ADDR_STATUS))
				status_d[2:0] = alu_res[2:0];
			if (res_to_file && (faddr == `ADDR_PORT))
				port_d = alu_res[5:0];
			pclr_d = res_to_file && (faddr == `ADDR_TIMER) &&
			         ctl_q[`CTL_PSA];
			if (flag_sel == UPD_CDCZ)
				status_d[2:0] = {alu_z, alu_dc, alu_c};
			else if (flag_sel == UPD_C)
				status_d[`ST_C] = alu_c;
			else if (flag_sel == UPD_Z)
				status_d[`ST_Z] = alu_z;
			if (push)
			begin
				stack_d[sp_q] = pc_q;
				sp_d          = 3'(sp_q + 3'h1);
			end
			if (pop)
				sp_d = 3'(sp_q - 3'h1);
			if (clr_wdt)
				status_d[4:3] = 2'b11;
			if (go_sleep)
			begin
				status_d[`ST_WDT_EXPIRY]  = 1'b1;
				status_d[`ST_SLEEP_ENTRY] = 1'b0;
			end
		end
		// Sleep entry wins over a wake request in the same cycle
		if (wake)
			sleep_d = 1'b0;
		if (exec && go_sleep)
			sleep_d = 1'b1;
		ctl_d = ctl_q;
		if (apb_wr && (PADDR_I == `REG_CONTROL))
			ctl_d = PWDATA_I[1:0];
		prdata_d = prdata_q;
		if (apb_rd)
		begin
			unique case (PADDR_I)
				`REG_CONTROL: prdata_d = {30'h0, ctl_q};
				`REG_STATE:   prdata_d = {15'h0, sleep_q, 3'h0, status_q, w_q};
				`REG_PC:      prdata_d = {19'h0, pc_q};
				default:      prdata_d = 32'h0;
			endcase
		end
	end

	// Registers
	always_ff @(posedge CLK_I)
	begin
		pin_meta_q <= PIN_I;
		pin_sync_q <= pin_meta_q;
		stack_q    <= stack_d;
		if (RESET_I)
		begin
			phase_q  <= 2'd0;
			instr_q  <= `NOP_WORD;
			pc_q     <= `RESET_PC;
			w_q      <= 8'h00;
			status_q <= `STATUS_RESET;
			port_q   <= 6'h00;
			pclr_q   <= 1'b0;
			sleep_q  <= 1'b0;
			sp_q     <= 3'h0;
			ctl_q    <= `CTL_RESET;
			prdata_q <= 32'h0;
		end
		else
		begin
			phase_q  <= phase_d;
			instr_q  <= instr_d;
			pc_q     <= pc_d;
			w_q      <= w_d;
			status_q <= status_d;
			port_q   <= port_d;
			pclr_q   <= pclr_d;
			sleep_q  <= sleep_d;
			sp_q     <= sp_d;
			ctl_q    <= ctl_d;
			prdata_q <= prdata_d;
		end
	end

	assign PRDATA_O          = prdata_q;
	assign PROG_ADDR_O       = pc_q;
	assign PORT_LATCH_O      = port_q;
	assign PRESCALER_CLEAR_O = pclr_q;
	assign SLEEP_O           = sleep_q;

	// Checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	sequence s_nop_slot;
		(instr_q == NOP_WORD) [*4];
	endsequence

	property p_add_decode;
		exec && (instr_q[13:8] == 6'b000111) |-> alu_op == ALU_ADD;
	endproperty
	a_add_decode: assert property (p_add_decode)
		else $error("add opcode not decoded");

	property p_dest_acc;
		exec && (instr_q[13:8] == 6'b001000) && !instr_q[7]
		|=> w_q == $past(operand) && $stable(port_q);
	endproperty
	a_dest_acc: assert property (p_dest_acc)
		else $error("move to accumulator misrouted");

	property p_rotate_flags;
		exec && (instr_q[13:9] == 5'b00110) && (faddr != `ADDR_STATUS)
		|=> status_q[2:1] == $past(status_q[2:1]);
	endproperty
	a_rotate_flags: assert property (p_rotate_flags)
		else $error("rotate touched DC or Z");

	property p_skip_zero;
		exec && is_skip_op(instr_q) && alu_z && (faddr != `ADDR_STATUS)
		|=> s_nop_slot and (status_q == $past(status_q));
	endproperty
	a_skip_zero: assert property (p_skip_zero)
		else $error("skip on zero failed");

	property p_bit_set;
		exec && (instr_q[13:10] == 4'b0101)
		|-> alu_res == (operand | (8'h01 << instr_q[9:7])) && ram_we ==
		    ((faddr != `ADDR_STATUS) && (faddr != `ADDR_PORT));
	endproperty
	a_bit_set: assert property (p_bit_set)
		else $error("bit set result wrong");

	property p_or_literal;
		exec && (instr_q[13:8] == 6'b111000)
		|=> w_q == ($past(w_q) | $past(instr_q[7:0])) &&
		    status_q[`ST_C] == $past(status_q[`ST_C]);
	endproperty
	a_or_literal: assert property (p_or_literal)
		else $error("literal OR wrong");

	property p_sub_literal;
		exec && (instr_q[13:9] == 5'b11110)
		|=> w_q == 8'($past(instr_q[7:0]) - $past(w_q));
	endproperty
	a_sub_literal: assert property (p_sub_literal)
		else $error("literal subtract wrong");

	property p_return_literal;
		exec && (instr_q[13:10] == 4'b1101)
		|=> w_q == $past(instr_q[7:0]) && PROG_ADDR_O == $past(top_addr);
	endproperty
	a_return_literal: assert property (p_return_literal)
		else $error("return with literal wrong");

	property p_branch_nop;
		exec && (branch || skip) |=> s_nop_slot;
	endproperty
	a_branch_nop: assert property (p_branch_nop)
		else $error("second cycle not a no-op");

	property p_sleep;
		exec && (instr_q == `SLEEP_WORD)
		|=> SLEEP_O && !status_q[`ST_SLEEP_ENTRY] ##1 $stable(phase_q);
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep not entered");

	property p_port_rmw;
		exec && (instr_q[13:7] == 7'b0010001) && (faddr == `ADDR_PORT)
		|=> PORT_LATCH_O == $past(pin_sync_q);
	endproperty
	a_port_rmw: assert property (p_port_rmw)
		else $error("port write-back not from pins");

	property p_prescaler_clear;
		exec && res_to_file && (faddr == `ADDR_TIMER) && ctl_q[`CTL_PSA]
		|=> PRESCALER_CLEAR_O ##1 !PRESCALER_CLEAR_O;
	endproperty
	a_prescaler_clear: assert property (p_prescaler_clear)
		else $error("prescaler clear missing");

	property p_cycle;
		running && (phase_q == 2'd0) ##1 running [*3]
		|-> phase_q == PHASE_EXEC;
	endproperty
	a_cycle: assert property (p_cycle)
		else $error("instruction cycle not four clocks");

endmodule
`default_nettype wire

// ---- src/decoder_cfg.svh ----
// Constants of the 14-bit instruction decoder: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design files of this block.
`ifndef DECODER_CFG_SVH
`define DECODER_CFG_SVH

// Timing
`define CLK_PERIOD_NS   50
`define INSTR_CYCLE_NS  200
`define PHASE_COUNT     (`INSTR_CYCLE_NS / `CLK_PERIOD_NS)

// Fixed words and reset values
`define NOP_WORD        14'h0000
`define SLEEP_WORD      14'h0063
`define WDT_CLEAR_WORD  14'h0064
`define RESET_PC        13'h0000
`define STATUS_RESET    5'h18
`define CTL_RESET       2'h0

// File addresses with special meaning
`define ADDR_TIMER      7'h01
`define ADDR_STATUS     7'h03
`define ADDR_PORT       7'h05

// Status bit positions
`define ST_C            0
`define ST_DC           1
`define ST_Z            2
`define ST_SLEEP_ENTRY  3
`define ST_WDT_EXPIRY   4

// Bus register offsets and control bit positions
`define REG_CONTROL     8'h00
`define REG_STATE       8'h04
`define REG_PC          8'h08
`define CTL_RUN         0
`define CTL_PSA         1
`define CTL_WAKE        2

`endif

// ---- src/decoder_pkg.sv ----
// Types shared by the decoder core and its arithmetic unit.
// Assumes nothing beyond a SystemVerilog compiler.
package decoder_pkg;

	// Arithmetic unit operations
	typedef enum logic [3:0] {
		ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_PASS, ALU_COM,
		ALU_INC, ALU_DEC, ALU_SWAP, ALU_RL, ALU_RR, ALU_CLR, ALU_BCLR,
		ALU_BSET
	} alu_op_type;

	// Which status flags an instruction updates
	typedef enum logic [1:0] {
		UPD_NONE, UPD_Z, UPD_C, UPD_CDCZ
	} flag_sel_type;

endpackage

// ---- src/alu_unit.sv ----
// Combinational arithmetic unit for the decoder core.
// Assumes operands are stable during the execute phase of the core.
`timescale 1ns/10ps
`default_nettype none
module alu_unit (
	input  var   decoder_pkg::alu_op_type op_i,
	input  wire  logic [7:0]              a_i,
	input  wire  logic [7:0]              w_i,
	input  wire  logic [2:0]              bit_i,
	input  wire  logic                    cin_i,
	output logic [7:0]                    res_o,
	output logic                          c_o,
	output logic                          dc_o,
	output logic                          z_o
);
	import decoder_pkg::*;

	logic [8:0] sum;
	logic [4:0] nib_sum;
	logic [7:0] mask;

	// Result and flags per operation
	always_comb
	begin
		sum     = {1'b0, a_i} + {1'b0, w_i};
		nib_sum = {1'b0, a_i[3:0]} + {1'b0, w_i[3:0]};
		mask    = 8'h01 << bit_i;
		res_o   = a_i;
		c_o     = cin_i;
		dc_o    = 1'b0;
		unique case (op_i)
			ALU_ADD:
			begin
				res_o = sum[7:0];
				c_o   = sum[8];
				dc_o  = nib_sum[4];
			end
			ALU_SUB:
			begin
				res_o = a_i - w_i;
				c_o   = (a_i >= w_i);         // Carry is no-borrow
				dc_o  = (a_i[3:0] >= w_i[3:0]);
			end
			ALU_AND:  res_o = a_i & w_i;
			ALU_OR:   res_o = a_i | w_i;
			ALU_XOR:  res_o = a_i ^ w_i;
			ALU_PASS: res_o = a_i;
			ALU_COM:  res_o = ~a_i;
			ALU_INC:  res_o = a_i + 8'h01;
			ALU_DEC:  res_o = a_i - 8'h01;
			ALU_SWAP: res_o = {a_i[3:0], a_i[7:4]};
			ALU_RL:
			begin
				res_o = {a_i[6:0], cin_i};
				c_o   = a_i[7];
			end
			ALU_RR:
			begin
				res_o = {cin_i, a_i[7:1]};
				c_o   = a_i[0];
			end
			ALU_CLR:  res_o = 8'h00;
			ALU_BCLR: res_o = a_i & ~mask;
			ALU_BSET: res_o = a_i | mask;
		endcase
		z_o = (res_o == 8'h00);
	end

endmodule
`default_nettype wire

// ---- src/file_ram.sv ----
// Data register file of 128 bytes with one read and one write port.
// Assumes the core issues reads a cycle before it needs the data.
`timescale 1ns/10ps
`default_nettype none
module file_ram (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       rd_en_i,
	input  wire logic [6:0] rd_addr_i,
	input  wire logic       wr_en_i,
	input  wire logic [6:0] wr_addr_i,
	input  wire logic [7:0] wr_data_i,
	output logic      [7:0] rd_data_o
);
	logic [7:0] mem [0:127];

	// Storage and registered read data
	always_ff @(posedge clk_i)
	begin
		if (wr_en_i)
			mem[wr_addr_i] <= wr_data_i;
		if (reset_i)
			rd_data_o <= 8'h00;
		else if (rd_en_i)
			rd_data_o <= mem[rd_addr_i];
	end

endmodule
`default_nettype wire

// ---- tb/prog_mem_model.sv ----
// Behavioural program memory facing the decoder's fetch port.
// Assumes the bench loads words while the core is held in reset.
`timescale 1ns/10ps
`default_nettype none
module prog_mem_model (
	input  wire logic        clk_i,
	input  wire logic        load_en_i,
	input  wire logic [3:0]  load_addr_i,
	input  wire logic [13:0] load_word_i,
	input  wire logic [12:0] addr_i,
	output logic      [13:0] word_o
);
	logic [13:0] mem_q [16];
	logic [12:0] last_q;

	// Word settles two clocks after an address change, junk meanwhile
	always_ff @(posedge clk_i)
	begin
		if (load_en_i)
			mem_q[load_addr_i] <= load_word_i;
		last_q <= addr_i;
		word_o <= (addr_i != last_q) ? ~word_o : mem_q[addr_i[3:0]];
	end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench: runs short programs and reads results over APB.
// Assumes the decoder core, its package and the memory model are compiled.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [5:0]  pins = 6'h00;
	logic        ld_en = 1'b0;
	logic [3:0]  ld_addr = 4'h0;
	logic [13:0] ld_word = 14'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        psc_clr;
	logic        sleeping;
	logic [12:0] prog_addr;
	logic [13:0] prog_word;
	logic [5:0]  latch;
	logic [32:0] expq [$];
	logic [31:0] seed = 32'hf26a;
	logic [15:0] tbl [25] = '{16'h0700, 16'h4780, 16'h0200, 16'h0500,
		16'h0400, 16'h0600, 16'h0900, 16'h0a00, 16'h0300, 16'h0e00,
		16'h0d00, 16'h0c00, 16'h0800, 16'h8b00, 16'h8f00, 16'h5000,
		16'h5400, 16'h9800, 16'h9c00, 16'h3800, 16'h3900, 16'h3a00,
		16'h3c00, 16'h3e00, 16'h2008};
	int          err_total = 0;
	int          comparisons = 0;
	int          pulses = 0;
	int          cyc = 0;

	instr_decoder i_dut (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .PROG_ADDR_O(prog_addr),
		.PROG_WORD_I(prog_word), .PIN_I(pins), .PORT_LATCH_O(latch),
		.PRESCALER_CLEAR_O(psc_clr), .SLEEP_O(sleeping));
	prog_mem_model i_mem (.clk_i(clk), .load_en_i(ld_en),
		.load_addr_i(ld_addr), .load_word_i(ld_word),
		.addr_i(prog_addr), .word_o(prog_word));

	// Clock of 50 ns
	initial
	begin
		forever #25 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// Accumulator and flags expected after one operation
	function automatic logic [10:0] model(input logic [13:0] wd,
		input logic [7:0] f, input logic [7:0] w);
		logic [7:0] x;
		logic [7:0] r;
		logic [2:0] b;
		logic       ar;
		logic       sb;
		logic       c;
		logic       dc;
		logic       z;
		x = (wd[13:12] == 2'b11) ? wd[7:0] : f;
		b = wd[9:7];
		casez (wd[13:8])
			6'h07, 6'b11111?: r = x + w;
			6'h02, 6'b11110?: r = x - w;
			6'h05, 6'h39: r = x & w;
			6'h04, 6'h38: r = x | w;
			6'h06, 6'h3a: r = x ^ w;
			6'h08: r = wd[7] ? w : x;
			6'h09: r = ~x;
			6'h0a: r = x + 8'h01;
			6'h03: r = x - 8'h01;
			6'h0e: r = {x[3:0], x[7:4]};
			6'h0d: r = {x[6:0], 1'b0};
			6'h0c: r = {1'b0, x[7:1]};
			6'h0b: r = (x == 8'h01) ? 8'h00 : 8'h55;
			6'h0f: r = (x == 8'hff) ? 8'h00 : 8'h55;
			6'b0100??: r = x & ~(8'h01 << b);
			6'b0101??: r = x | (8'h01 << b);
			6'b0110??: r = x[b] ? 8'h55 : w;
			6'b0111??: r = x[b] ? w : 8'h55;
			6'h20: r = x;
			default: r = w;
		endcase
		ar = wd[13:8] == 6'h07 || wd[13:9] == 5'b11111;
		sb = wd[13:8] == 6'h02 || wd[13:9] == 5'b11110;
		c = ar ? ({1'b0, x} + w > 9'h0ff) : sb ? (x >= w) :
			(wd[13:8] == 6'h0d) ? x[7] : (wd[13:8] == 6'h0c) && x[0];
		dc = ar ? (x[3:0] + w[3:0] > 15) : sb && (x[3:0] >= w[3:0]);
		z = !(wd[13:8] inside {6'h00, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f,
			6'h20} || wd[13:11] == 3'b011);
		z = z && ((wd[13:8] == 6'h08 ? x : r) == 8'h00);
		return {z, dc, c, r};
	endfunction

	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("err_total=%0d comparisons=%0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] ad,
		input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, input logic [32:0] exp);
		expq.push_back(exp);
		apb(1'b0, ad, 32'h0);
	endtask

	// Load a program, run it to the sleep word, read the outcome
	task automatic run_prog(input logic [7:0] a, input logic [7:0] w,
		input logic [6:0] f, input logic [13:0] op, input logic [13:0] ex,
		input logic psa);
		logic [13:0] img [16];
		int          p0;
		int          n;
		foreach (img[i])
			img[i] = 14'h0000;
		img[0] = 14'h3000 | a;
		img[1] = 14'h0080 | f;
		img[2] = 14'h3000 | w;
		img[3] = op;
		img[4] = ex;
		img[5] = 14'h0063;
		img[8] = 14'h3400 | a;
		rst <= 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			@(posedge clk);
			ld_en <= 1'b1;
			ld_addr <= i[3:0];
			ld_word <= img[i];
		end
		@(posedge clk);
		ld_en <= 1'b0;
		rst <= 1'b0;
		p0 = pulses;
		apb(1'b1, 8'h00, {30'h0, psa, 1'b1});
		n = 0;
		while (sleeping !== 1'b1 && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		rd(8'h04, {1'b0, 32'h00011000 | {21'h0, model(op,
			(f == 7'h05) ? {2'b00, pins} : a, w)}});
		check(33'(pulses - p0), {32'h0, f == 7'h01 && psa});
		if (f == 7'h05)
			check({27'h0, latch}, {27'h0, pins});
	endtask

	// Read answers are compared in order at the access edge
	always @(posedge clk)
	begin
		if (psel && penable && !pwrite && pready === 1'b1)
			check({pslverr, prdata}, expq.pop_front());
	end

	// Prescaler pulse counter and run limit
	always @(posedge clk)
	begin
		cyc++;
		if (psc_clr === 1'b1)
			pulses++;
		if (cyc == 60000)
		begin
			err_total++;
			final_report();
		end
	end

	// Main sequence
	initial
	begin
		logic [7:0]  a;
		logic [6:0]  f;
		logic [15:0] e;
		logic [13:0] op;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(8'h00, 33'h0);
		rd(8'h08, 33'h0);
		rd(8'h0c, {1'b1, 32'h0});
		for (int p = 0; p < 4; p++)
		begin
			for (int t = 0; t < 25; t++)
			begin
				seed = xs(seed);
				a = (p == 0) ? 8'h01 : (p == 1) ? 8'hff :
					(p == 2) ? 8'h00 : seed[31:24];
				f = {2'b01, seed[20:16]};
				e = tbl[t];
				op = e[13:0];
				if (op[13:12] == 2'b11)
					op = op | {6'h0, seed[7:0]};
				else if (op[13:12] != 2'b10)
					op = op | {7'h0, f} | (op[13:12] == 2'b01 ?
						{4'h0, seed[2:0], 7'h0} : 14'h0);
				run_prog(a, seed[15:8], f, op, (e[15:14] == 2'd1) ?
					(14'h0800 | f) : (e[15:14] == 2'd2) ? 14'h3055 :
					14'h0, 1'b0);
			end
			pins <= seed[29:24];
			run_prog(8'hff, seed[15:8], 7'h05, 14'h0885, 14'h0, 1'b0);
			run_prog(a, seed[15:8], 7'h01, 14'h0, 14'h0, seed[31]);
			run_prog(a, seed[15:8], 7'h01, 14'h0, 14'h0, 1'b1);
		end
		apb(1'b1, 8'h00, 32'h7);
		rd(8'h00, 33'h3);
		@(negedge clk);
		check({32'h0, sleeping}, 33'h0);
		final_report();
	end
endmodule
`default_nettype wire
